// ### design/rcb_top.sv
/*
 * rcb_top: reset-cause log and brown-out control with an APB slave,
 * cause-event interrupt status, enable and clear registers.
 * Assumes presetn is the power-on reset of this always-on logic, and that
 * the cause inputs are one-cycle pulses synchronous to pclk, raised by the
 * core and reset controller as each cause is detected.
 */
`timescale 1ns/1ps
// Contract
// RL1: a stack overflow sets bit 7 to one and firmware may clear it by writing zero.
// RL2: a stack underflow sets bit 6 to one and firmware may clear it by writing zero.
// RL3: a watchdog clear inside the closed window drives bit 5 to zero until firmware sets it.
// RL4: a watchdog time-out reset drives bit 4 to zero; one means none or firmware wrote one.
// RL5: an external pin reset drives bit 3 to zero, held until firmware writes one.
// RL6: the software reset instruction drives bit 2 to zero, held until firmware writes one.
// RL7: a power-on reset drives bit 1 to zero; one means none since firmware wrote one.
// RL8: a brown-out reset drives bit 0 to zero; one means none since firmware wrote one.
// RL9: firmware can write every cause flag to re-arm it for a later cause.
// RL10: the software enable switches brown-out reset only when the config field is 01.
// RL11: ready reads one only while the detector is active and armed after warm-up.
// RL12: bits 6 to 1 of the brown-out control register read zero and ignore writes.
// RL13: each cause updates only its own flag and leaves the others unchanged.
module rcb_top
  import rcb_pkg::*;
#(
  parameter int unsigned ADDR_W     = 8,
  parameter int unsigned WARMUP_CYC = BROWNOUT_WARMUP_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              stack_overflow_evt,
  input  wire logic              stack_underflow_evt,
  input  wire logic              watchdog_window_evt,
  input  wire logic              watchdog_timeout_evt,
  input  wire logic              master_clear_pin_evt,
  input  wire logic              sw_reset_instr_evt,
  input  wire logic              power_on_evt,
  input  wire logic              brownout_evt,
  input  wire logic [1:0]        brownout_config_field,
  output logic                   brownout_enable,
  output logic                   irq
);

  generate
    if (ADDR_W < 5) begin : g_bad_addr
      $error("ADDR_W must be at least 5 to reach every register");
    end
  endgenerate

  logic [NUM_CAUSE-1:0] cause_evt;
  logic [NUM_CAUSE-1:0] cause_flags;
  logic                 apb_setup;
  logic                 apb_done;
  logic                 wr_lane0;
  logic                 hit_cause;
  logic                 hit_brownout;
  logic                 hit_irq_status;
  logic                 hit_irq_enable;
  logic                 hit_irq_clear;
  logic                 mapped;
  logic                 sw_en_r;
  logic                 brownout_ready;
  logic                 brownout_active;
  logic [NUM_CAUSE-1:0] irq_status_r;
  logic [NUM_CAUSE-1:0] irq_enable_r;
  logic [NUM_CAUSE-1:0] irq_clear;
  logic [31:0]          rd_nxt;
  logic                 pready_r;
  logic                 pslverr_r;
  logic [31:0]          prdata_r;
  logic                 brownout_enable_r;
  logic                 irq_r;

  assign cause_evt[STACK_OVF_BIT]    = stack_overflow_evt;
  assign cause_evt[STACK_UNF_BIT]    = stack_underflow_evt;
  assign cause_evt[WDT_WINDOW_BIT]   = watchdog_window_evt;
  assign cause_evt[WDT_TIMEOUT_BIT]  = watchdog_timeout_evt;
  assign cause_evt[EXT_PIN_BIT]      = master_clear_pin_evt;
  assign cause_evt[SW_INSTR_BIT]     = sw_reset_instr_evt;
  assign cause_evt[POWER_ON_BIT]     = power_on_evt;
  assign cause_evt[BROWNOUT_RST_BIT] = brownout_evt;

  // apb decode; upper address bits beyond the map make the access unmapped
  assign apb_setup      = psel && !penable;
  assign apb_done       = psel && penable && pready_r;
  assign wr_lane0       = apb_done && pwrite && pstrb[0];
  assign hit_cause      = (paddr == ADDR_W'(OFS_CAUSE));
  assign hit_brownout   = (paddr == ADDR_W'(OFS_BROWNOUT));
  assign hit_irq_status = (paddr == ADDR_W'(OFS_IRQ_STATUS));
  assign hit_irq_enable = (paddr == ADDR_W'(OFS_IRQ_ENABLE));
  assign hit_irq_clear  = (paddr == ADDR_W'(OFS_IRQ_CLEAR));
  assign mapped         = hit_cause || hit_brownout || hit_irq_status ||
                          hit_irq_enable || hit_irq_clear;

  // one flag per cause; each sees only its own event
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CAUSE; gi++) begin : g_flag
      rcb_cause_flag #(
        .RST_VAL (CAUSE_RST_VAL[gi]),
        .HW_VAL  (CAUSE_HW_VAL[gi])                // see RL1 RL2 RL3 RL4 RL5 RL6 RL7 RL8
      ) u_flag (
        .clk       (pclk),
        .rst_n     (presetn),
        .cause_evt (cause_evt[gi]),               // see RL13
        .wr_en     (wr_lane0 && hit_cause),       // see RL9
        .wr_val    (pwdata[gi]),
        .flag_r    (cause_flags[gi])
      );
    end
  endgenerate

  // only bit 7 is stored; bits 6..1 have no storage at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_en_r <= BROWNOUT_SW_EN_RST;
    end else if (wr_lane0 && hit_brownout) begin
      sw_en_r <= pwdata[BROWNOUT_SW_EN_BIT];  // see RL12
    end
  end

  // any config other than off or software-controlled keeps the detector on
  assign brownout_active = (brownout_config_field == BROWNOUT_CFG_SW) ? sw_en_r :
                           (brownout_config_field != BROWNOUT_CFG_OFF);  // see RL10

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brownout_enable_r <= 1'b0;
    end else begin
      brownout_enable_r <= brownout_active;  // see RL10
    end
  end

  rcb_brownout_arm #(
    .WARMUP_CYC (WARMUP_CYC)
  ) u_arm (
    .clk     (pclk),
    .rst_n   (presetn),
    .active  (brownout_enable_r),
    .ready_r (brownout_ready)                  // see RL11
  );

  // interrupt status: event sets win over a clear in the same cycle
  assign irq_clear = (wr_lane0 && hit_irq_clear) ? pwdata[NUM_CAUSE-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clear) | cause_evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_r <= IRQ_ENABLE_RST;
    end else if (wr_lane0 && hit_irq_enable) begin
      irq_enable_r <= pwdata[NUM_CAUSE-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_status_r & irq_enable_r);
    end
  end

  // read data is captured in the setup cycle so prdata leaves a flop
  always_comb begin
    rd_nxt = '0;
    if (hit_cause) begin
      rd_nxt[NUM_CAUSE-1:0] = cause_flags;
    end else if (hit_brownout) begin
      rd_nxt[BROWNOUT_SW_EN_BIT] = sw_en_r;
      rd_nxt[BROWNOUT_RDY_BIT]   = brownout_ready;   // see RL11
    end else if (hit_irq_status) begin
      rd_nxt[NUM_CAUSE-1:0] = irq_status_r;
    end else if (hit_irq_enable) begin
      rd_nxt[NUM_CAUSE-1:0] = irq_enable_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else if (apb_setup) begin
      pready_r  <= 1'b1;
      pslverr_r <= !mapped;
      prdata_r  <= pwrite ? 32'h0000_0000 : rd_nxt;
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign brownout_enable = brownout_enable_r;
  assign irq             = irq_r;

  // checks
  sequence s_cause_wr;
    wr_lane0 && hit_cause;
  endsequence

  sequence s_brownout_rd;
    apb_setup && !pwrite && hit_brownout;
  endsequence

  a_stack_ovf : assert property (@(posedge pclk) disable iff (!presetn) // see RL1
    stack_overflow_evt |=> cause_flags[STACK_OVF_BIT])
    else $error("stack overflow did not set its flag");

  a_stack_unf : assert property (@(posedge pclk) disable iff (!presetn) // see RL2
    stack_underflow_evt |=> cause_flags[STACK_UNF_BIT])
    else $error("stack underflow did not set its flag");

  a_wdt_window : assert property (@(posedge pclk) disable iff (!presetn) // see RL3
    watchdog_window_evt |=> !cause_flags[WDT_WINDOW_BIT])
    else $error("window violation did not clear its flag");

  a_wdt_timeout : assert property (@(posedge pclk) disable iff (!presetn) // see RL4
    watchdog_timeout_evt |=> !cause_flags[WDT_TIMEOUT_BIT])
    else $error("watchdog time-out did not clear its flag");

  a_pin_hold : assert property (@(posedge pclk) disable iff (!presetn) // see RL5
    (!cause_flags[EXT_PIN_BIT] && !(wr_lane0 && hit_cause))
      |=> !cause_flags[EXT_PIN_BIT])
    else $error("pin reset flag rose without a firmware write");

  a_sw_instr : assert property (@(posedge pclk) disable iff (!presetn) // see RL6
    sw_reset_instr_evt |=> !cause_flags[SW_INSTR_BIT])
    else $error("reset instruction did not clear its flag");

  a_power_on : assert property (@(posedge pclk) disable iff (!presetn) // see RL7
    power_on_evt |=> !cause_flags[POWER_ON_BIT])
    else $error("power-on did not clear its flag");

  a_brownout_flag : assert property (@(posedge pclk) disable iff (!presetn) // see RL8
    brownout_evt |=> !cause_flags[BROWNOUT_RST_BIT])
    else $error("brown-out did not clear its flag");

  a_fw_rearm : assert property (@(posedge pclk) disable iff (!presetn) // see RL9
    (s_cause_wr and (cause_evt == '0)) |=> (cause_flags == $past(pwdata[7:0])))
    else $error("firmware write to cause register not stored");

  a_sw_enable : assert property (@(posedge pclk) disable iff (!presetn) // see RL10
    (brownout_config_field == BROWNOUT_CFG_SW)
      |=> (brownout_enable == $past(sw_en_r)))
    else $error("software enable not honoured in config 01");

  a_ready_active : assert property (@(posedge pclk) disable iff (!presetn) // see RL11
    brownout_ready |-> $past(brownout_enable_r) && $past(brownout_enable_r, 2))
    else $error("ready shown while detector off or not warmed");

  a_unimpl_zero : assert property (@(posedge pclk) disable iff (!presetn) // see RL12
    s_brownout_rd |=> (prdata[6:1] == 6'h00) && (prdata[31:8] == 24'h00_0000))
    else $error("unimplemented brown-out bits read non-zero");

  a_only_own : assert property (@(posedge pclk) disable iff (!presetn) // see RL13
    (stack_overflow_evt && !(wr_lane0 && hit_cause) && (cause_evt[6:0] == 7'h00))
      |=> (cause_flags[6:0] == $past(cause_flags[6:0])))
    else $error("a cause disturbed another flag");

  a_pin_evt : assert property (@(posedge pclk) disable iff (!presetn) // see RL5
    master_clear_pin_evt |=> !cause_flags[EXT_PIN_BIT])
    else $error("pin reset did not clear its flag");

  a_cfg_off : assert property (@(posedge pclk) disable iff (!presetn) // see RL10
    (brownout_config_field == BROWNOUT_CFG_OFF) |=> !brownout_enable)
    else $error("detector enabled while config is off");

  a_ready_drop : assert property (@(posedge pclk) disable iff (!presetn) // see RL11
    !brownout_enable_r |=> !brownout_ready)
    else $error("ready stayed up after the detector was switched off");

  a_status_set : assert property (@(posedge pclk) disable iff (!presetn)
    (cause_evt != '0) |=> ((irq_status_r & $past(cause_evt)) == $past(cause_evt)))
    else $error("a cause event was lost from the interrupt status");

  a_irq_level : assert property (@(posedge pclk) disable iff (!presetn)
    ((irq_status_r & irq_enable_r) != '0) |=> irq)
    else $error("irq low while an enabled status bit is set");

  a_irq_quiet : assert property (@(posedge pclk) disable iff (!presetn)
    ((irq_status_r & irq_enable_r) == '0) |=> !irq)
    else $error("irq high with no enabled status bit set");

endmodule : rcb_top

// ### design/rcb_pkg.sv
/*
 * rcb_pkg: constants shared by the reset-cause and brown-out control block.
 * Assumes a 50 MHz pclk and 32-bit APB data with byte addresses.
 */
package rcb_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS         = 20;
  localparam int unsigned BROWNOUT_WARMUP_NS    = 1000;
  localparam int unsigned BROWNOUT_WARMUP_CYC   =
    (BROWNOUT_WARMUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] OFS_CAUSE      = 8'h00;
  localparam logic [7:0] OFS_BROWNOUT   = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h10;

  // reset-cause register fields
  localparam int unsigned NUM_CAUSE         = 8;
  localparam int unsigned STACK_OVF_BIT     = 7;
  localparam int unsigned STACK_UNF_BIT     = 6;
  localparam int unsigned WDT_WINDOW_BIT    = 5;
  localparam int unsigned WDT_TIMEOUT_BIT   = 4;
  localparam int unsigned EXT_PIN_BIT       = 3;
  localparam int unsigned SW_INSTR_BIT      = 2;
  localparam int unsigned POWER_ON_BIT      = 1;
  localparam int unsigned BROWNOUT_RST_BIT  = 0;
  // value each flag takes after presetn (presetn is the power-on event)
  localparam logic [7:0]  CAUSE_RST_VAL     = 8'h3D;
  // value hardware writes into each flag when its cause occurs
  localparam logic [7:0]  CAUSE_HW_VAL      = 8'hC0;

  // brown-out control register fields
  localparam int unsigned BROWNOUT_SW_EN_BIT = 7;
  localparam int unsigned BROWNOUT_RDY_BIT   = 0;
  localparam logic        BROWNOUT_SW_EN_RST = 1'b1;
  localparam logic [1:0]  BROWNOUT_CFG_OFF   = 2'h0;
  localparam logic [1:0]  BROWNOUT_CFG_SW    = 2'h1;

  // interrupt registers
  localparam logic [7:0]  IRQ_ENABLE_RST     = 8'h00;

  typedef enum logic [1:0] {
    ARM_OFF,
    ARM_WARMING,
    ARM_READY
  } rcb_arm_e;

endpackage : rcb_pkg

// ### design/rcb_cause_flag.sv
/*
 * rcb_cause_flag: one reset-cause flag, written by hardware on its cause
 * and by firmware otherwise.
 * Assumes event and write are synchronous single-cycle pulses on clk.
 */
`timescale 1ns/1ps
module rcb_cause_flag
  import rcb_pkg::*;
#(
  parameter logic RST_VAL = 1'b1,
  parameter logic HW_VAL  = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cause_evt,
  input  wire logic wr_en,
  input  wire logic wr_val,
  output logic      flag_r
);

  // hardware wins over a firmware write in the same cycle so no cause is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= RST_VAL;
    end else if (cause_evt) begin
      flag_r <= HW_VAL;
    end else if (wr_en) begin
      flag_r <= wr_val;
    end
  end

  a_hw_priority : assert property (@(posedge clk) disable iff (!rst_n)
    (cause_evt && wr_en && (wr_val != HW_VAL)) |=> (flag_r == HW_VAL))
    else $error("firmware write overrode a hardware cause");

endmodule : rcb_cause_flag

// ### design/rcb_brownout_arm.sv
/*
 * rcb_brownout_arm: warm-up tracking of the brown-out detector.
 * Assumes active is a registered level on clk; ready follows after warm-up.
 */
`timescale 1ns/1ps
module rcb_brownout_arm
  import rcb_pkg::*;
#(
  parameter int unsigned WARMUP_CYC = BROWNOUT_WARMUP_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic active,
  output logic      ready_r
);

  localparam int unsigned CW = $clog2(WARMUP_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(WARMUP_CYC - 1);

  generate
    if (WARMUP_CYC < 1) begin : g_bad_warmup
      $error("WARMUP_CYC must be at least 1");
    end
  endgenerate

  rcb_arm_e        state_r;
  logic [CW-1:0]   cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ARM_OFF;
    end else begin
      case (state_r)
        ARM_OFF:     state_r <= active ? ARM_WARMING : ARM_OFF;
        ARM_WARMING: begin
          if (!active) begin
            state_r <= ARM_OFF;
          end else if (cnt_r == LAST) begin
            state_r <= ARM_READY;
          end
        end
        ARM_READY:   state_r <= active ? ARM_READY : ARM_OFF;
        default:     state_r <= ARM_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (state_r == ARM_WARMING && active) begin
      cnt_r <= cnt_r + CW'(1);
    end else begin
      cnt_r <= '0;
    end
  end

  // ready drops at the first edge that samples active low, one edge after the detector is switched off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= active && (state_r == ARM_READY ||
                            (state_r == ARM_WARMING && cnt_r == LAST));
    end
  end

endmodule : rcb_brownout_arm

// ### tb/test_reset_cause_and_brownout_control.sv
/*
 * test_reset_cause_and_brownout_control: self-checking bench for rcb_top.
 * Assumes rcb_pkg is compiled first; the bench drives every port itself.
 */
`timescale 1ns/1ps
module test_reset_cause_and_brownout_control
  import rcb_pkg::*;
;
  localparam int unsigned WCYC = 2;

  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [3:0]  pstrb   = 4'hF;
  logic [7:0]  evt     = 8'h00;
  logic [1:0]  cfg     = 2'h1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        bo_en;
  logic        irq;
  int          err_count = 0;
  int          compares  = 0;
  int          cyc       = 0;

  always #10 pclk = ~pclk;

  rcb_top #(.ADDR_W(8), .WARMUP_CYC(WCYC)) u_rcb_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stack_overflow_evt(evt[7]), .stack_underflow_evt(evt[6]),
    .watchdog_window_evt(evt[5]), .watchdog_timeout_evt(evt[4]),
    .master_clear_pin_evt(evt[3]), .sw_reset_instr_evt(evt[2]),
    .power_on_evt(evt[1]), .brownout_evt(evt[0]),
    .brownout_config_field(cfg), .brownout_enable(bo_en), .irq(irq)
  );

  task end_of_test;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // a hang anywhere ends up in the same closing report
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task chk_pin(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: pin got %b expected %b", $time, got, exp);
    end
  endtask : chk_pin

  // the request stands until the edge at which pready is seen high; data is taken there
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd_v, output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    er   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk_pin(e, 1'b0);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk_reg(r, exp);
    chk_pin(e, 1'b0);
  endtask : rd

  task pulse(input int i);
    @(posedge pclk);
    evt[i] <= 1'b1;
    @(posedge pclk);
    evt <= 8'h00;
  endtask : pulse

  task do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  task t_reset_values;
    rd(OFS_CAUSE, 32'h0000_003D);
    rd(OFS_IRQ_ENABLE, 32'h0000_0000);
    rd(OFS_IRQ_STATUS, 32'h0000_0000);
    repeat (WCYC + 3) @(posedge pclk);
    rd(OFS_BROWNOUT, 32'h0000_0081);
  endtask : t_reset_values

  // each cause flips only its own bit away from a base where every flag is re-armed
  task t_causes;
    logic [31:0] exp;
    wr(OFS_IRQ_ENABLE, 32'h0000_00FF);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CAUSE, 32'h0000_003F);
      exp = 32'h0000_003F ^ (32'h1 << i);
      pulse(i);
      @(posedge pclk);
      @(negedge pclk);
      chk_pin(irq, 1'b1);
      rd(OFS_CAUSE, exp);
      rd(OFS_IRQ_STATUS, 32'h1 << i);
      wr(OFS_IRQ_CLEAR, 32'h1 << i);
      repeat (2) @(negedge pclk);
      chk_pin(irq, 1'b0);
      rd(OFS_IRQ_STATUS, 32'h0000_0000);
    end
  endtask : t_causes

  task t_mask;
    wr(OFS_IRQ_ENABLE, 32'h0000_0000);
    pulse(0);
    repeat (3) @(negedge pclk);
    chk_pin(irq, 1'b0);
    rd(OFS_IRQ_STATUS, 32'h0000_0001);
    wr(OFS_IRQ_CLEAR, 32'h0000_0001);
    rd(OFS_IRQ_STATUS, 32'h0000_0000);
  endtask : t_mask

  task t_firmware_write;
    wr(OFS_CAUSE, 32'h0000_0000);
    rd(OFS_CAUSE, 32'h0000_0000);
    wr(OFS_CAUSE, 32'h0000_00FF);
    rd(OFS_CAUSE, 32'h0000_00FF);
  endtask : t_firmware_write

  task t_brownout;
    wr(OFS_BROWNOUT, 32'h0000_00FF);
    rd(OFS_BROWNOUT, 32'h0000_0081);
    wr(OFS_BROWNOUT, 32'h0000_0000);
    repeat (2) @(negedge pclk);
    chk_pin(bo_en, 1'b0);
    rd(OFS_BROWNOUT, 32'h0000_0000);
    @(posedge pclk);
    cfg <= 2'h2;
    repeat (2) @(negedge pclk);
    chk_pin(bo_en, 1'b1);
    repeat (WCYC + 3) @(posedge pclk);
    rd(OFS_BROWNOUT, 32'h0000_0001);
    cfg <= 2'h0;
    repeat (2) @(negedge pclk);
    chk_pin(bo_en, 1'b0);
    rd(OFS_BROWNOUT, 32'h0000_0000);
    cfg <= 2'h3;
    repeat (2) @(negedge pclk);
    chk_pin(bo_en, 1'b1);
    @(posedge pclk);
    cfg <= 2'h1;
    wr(OFS_BROWNOUT, 32'h0000_0080);
    repeat (2) @(negedge pclk);
    chk_pin(bo_en, 1'b1);
    repeat (WCYC + 3) @(posedge pclk);
    rd(OFS_BROWNOUT, 32'h0000_0081);
  endtask : t_brownout

  task t_unmapped;
    logic [31:0] r;
    logic        e;
    apb(1'b0, 8'h14, 32'h0000_0000, r, e);
    chk_pin(e, 1'b1);
    chk_reg(r, 32'h0000_0000);
    apb(1'b1, 8'h14, 32'h0000_0000, r, e);
    chk_pin(e, 1'b1);
    rd(OFS_IRQ_CLEAR, 32'h0000_0000);
    rd(OFS_CAUSE, 32'h0000_00FF);
    @(negedge pclk);
    chk_pin(pready, 1'b0);
  endtask : t_unmapped

  task t_second_reset;
    do_reset();
    rd(OFS_CAUSE, 32'h0000_003D);
    repeat (WCYC + 3) @(posedge pclk);
    rd(OFS_BROWNOUT, 32'h0000_0081);
  endtask : t_second_reset

  initial begin
    do_reset();
    t_reset_values();
    t_causes();
    t_mask();
    t_firmware_write();
    t_brownout();
    t_unmapped();
    t_second_reset();
    end_of_test();
  end
endmodule : test_reset_cause_and_brownout_control
